// ---- logic/mmpc_consts.vh ----
/*
 * mmpc_consts.vh: constants for the memory-mode pin multiplexer.
 * Assumes it is included by bare name from the mmpc design files.
 */
`ifndef MMPC_CONSTS_VH
`define MMPC_CONSTS_VH

// mode encodings, as seen on the mode-c strap during reset
`define MMPC_MODE_FULL      1'b0
`define MMPC_MODE_HOST      1'b1

// strap positions inside the captured strap vector
`define MMPC_STRAP_A        0
`define MMPC_STRAP_B        1
`define MMPC_STRAP_C        2

// data bus field positions
`define MMPC_BYTE_HI_LSB    16
`define MMPC_UPPER_LSB      8

// reset values of pin-side registers
`define MMPC_RST_STRAPS     3'h0
`define MMPC_RST_SELECTS_N  4'hf
`define MMPC_RST_ACK_N      1'b1
`define MMPC_RST_ADDR       14'h0000
`define MMPC_RST_DATA       24'h000000
`define MMPC_RST_DATA_OE    24'h000000
`define MMPC_RST_HAD        16'h0000
`define MMPC_RST_FLAG_OE    3'h0
`define MMPC_RST_IRQ_OE     4'h0

// two-flop synchroniser depth
`define MMPC_SYNC_STAGES    2

`endif

// ---- logic/mmpc_sync.v ----
/*
 * mmpc_sync.v: two-flop synchroniser for a vector of pin inputs.
 * Assumes each bit is an independent level; no bus coherence is given.
 */
`timescale 1ns/1ns

module mmpc_sync #(
    parameter W = 1
) (
    // clock
    input  wire         clk,
    // asynchronous levels in
    input  wire [W-1:0] d,
    // synchronised levels out
    output reg  [W-1:0] q
);

    reg [W-1:0] meta_q;

    // first stage is read by the second stage only
    always @(posedge clk) begin
        meta_q <= d;
        q      <= meta_q;
    end

endmodule // mmpc_sync

// ---- logic/mmpc_pin_mux.v ----
/*
 * mmpc_pin_mux.v: reset-time memory-mode latch and the pin multiplexing it steers:
 * external address/data buses, host address/data port with strobes, mode straps
 * reused as flags, and interrupt/flag shared pins.
 * Assumes core-side inputs are on SYS_CLK; all pin inputs are asynchronous.
 * RST must be held at least 3 SYS_CLK edges so the straps reach the latch.
 */
// What this block does
// - mode is taken from the strap during reset, then frozen while running
// - strap low at reset selects full memory mode
// - strap high at reset selects host mode
// - full mode drives the 14-bit external address bus
// - full mode uses 24-bit data; byte access drives top 8 as address
// - host mode offers 16-bit multiplexed host address/data bus
// - host mode keeps only the lowest external address output
// - host mode keeps only upper sixteen data lines
// - host mode takes four host strobes and returns port acknowledge
// - strap pins are mode inputs in reset, programmable flags afterwards
// - interrupt/flag shared pins keep both functions at once
`timescale 1ns/1ns
`include "mmpc_consts.vh"

module mmpc_pin_mux (
    // clock and reset
    input  wire        SYS_CLK,
    input  wire        RST,
    // latched mode
    output wire        HOST_MODE,
    output wire [2:0]  MODE_STRAPS,
    // strap / programmable flag pins
    input  wire [2:0]  PROG_FLAG_I,
    output wire [2:0]  PROG_FLAG_O,
    output wire [2:0]  PROG_FLAG_OE,
    // core side of the programmable flags
    input  wire [2:0]  CORE_FLAG_OUT,
    input  wire [2:0]  CORE_FLAG_DIR,
    output wire [2:0]  CORE_FLAG_IN,
    // interrupt/flag shared pins
    input  wire [3:0]  IRQ_FLAG_I,
    output wire [3:0]  IRQ_FLAG_O,
    output wire [3:0]  IRQ_FLAG_OE,
    // core side of the shared pins
    input  wire [3:0]  CORE_IRQ_FLAG_OUT,
    input  wire [3:0]  CORE_IRQ_FLAG_DIR,
    output wire [3:0]  CORE_IRQ_FLAG_IN,
    output wire [3:0]  CORE_IRQ_REQ_N,
    // core side of the external memory bus
    input  wire [13:0] CORE_ADDR,
    input  wire [23:0] CORE_DATA_OUT,
    input  wire        CORE_DATA_DRIVE,
    input  wire        CORE_BYTE_ACCESS,
    input  wire [7:0]  CORE_BYTE_ADDR_HI,
    input  wire [3:0]  CORE_SELECTS_N,
    output wire [23:0] CORE_DATA_IN,
    // external memory bus pins
    output wire [13:0] EXT_ADDR_BUS,
    output wire [13:0] EXT_ADDR_OE,
    input  wire [23:0] EXT_DATA_I,
    output wire [23:0] EXT_DATA_O,
    output wire [23:0] EXT_DATA_OE,
    output wire        COMBINED_MEM_SELECT_N,
    output wire        PROGRAM_MEM_SELECT_N,
    output wire        DATA_MEM_SELECT_N,
    output wire        IO_MEM_SELECT_N,
    // core side of the internal dma port
    input  wire [15:0] CORE_HAD_OUT,
    input  wire        CORE_HAD_DRIVE,
    input  wire        CORE_HOST_ACK_N,
    output wire [15:0] CORE_HAD_IN,
    output wire        CORE_HOST_WR_N,
    output wire        CORE_HOST_RD_N,
    output wire        CORE_HOST_ALE,
    output wire        CORE_HOST_SEL_N,
    // host port pins
    input  wire [15:0] HOST_ADDR_DATA_BUS_I,
    output wire [15:0] HOST_ADDR_DATA_BUS_O,
    output wire [15:0] HOST_ADDR_DATA_BUS_OE,
    input  wire        HOST_WRITE_STROBE_N,
    input  wire        HOST_READ_STROBE_N,
    input  wire        HOST_ADDR_LATCH,
    input  wire        HOST_PORT_SELECT_N,
    output wire        HOST_PORT_ACK_N
);

    // synchronised pin levels
    wire [2:0]  flag_s;
    wire [3:0]  irqf_s;
    wire [23:0] data_s;
    wire [15:0] had_s;
    wire [3:0]  strb_s;

    mmpc_sync #(
        .W (51)
    ) u_sync (
        .clk (SYS_CLK),
        .d   ({PROG_FLAG_I, IRQ_FLAG_I, EXT_DATA_I, HOST_ADDR_DATA_BUS_I,
               HOST_WRITE_STROBE_N, HOST_READ_STROBE_N, HOST_ADDR_LATCH,
               HOST_PORT_SELECT_N}),
        .q   ({flag_s, irqf_s, data_s, had_s, strb_s})
    );

    // mode latch: tracks straps during reset, frozen from the release edge
    reg  [2:0]  straps_q;
    wire        host_q = (straps_q[`MMPC_STRAP_C] == `MMPC_MODE_HOST);

    always @(posedge SYS_CLK) begin
        if (RST) begin
            straps_q <= flag_s;
        end
    end

    // pin-side registers
    reg  [2:0]  flag_oe_q;
    reg  [2:0]  flag_o_q;
    reg  [3:0]  irq_oe_q;
    reg  [3:0]  irq_o_q;
    reg  [13:0] addr_q;
    reg  [13:0] addr_oe_q;
    reg  [23:0] dout_q;
    reg  [23:0] doe_q;
    reg  [3:0]  sel_n_q;
    reg  [15:0] had_o_q;
    reg  [15:0] had_oe_q;
    reg         ack_n_q;
    reg  [23:0] din_q;
    reg  [15:0] had_in_q;

    // next values
    reg  [13:0] addr_oe_d;
    reg  [23:0] dout_d;
    reg  [23:0] doe_d;

    always @* begin
        dout_d = CORE_DATA_OUT;
        if (host_q) begin
            addr_oe_d = 14'h0001;
            doe_d     = CORE_DATA_DRIVE ? 24'hffff00 : `MMPC_RST_DATA_OE;
        end else begin
            addr_oe_d = 14'h3fff;
            doe_d     = CORE_DATA_DRIVE ? 24'hffffff : `MMPC_RST_DATA_OE;
            if (CORE_BYTE_ACCESS) begin
                // top byte carries byte-memory address even on reads
                dout_d[23:`MMPC_BYTE_HI_LSB] = CORE_BYTE_ADDR_HI;
                doe_d[23:`MMPC_BYTE_HI_LSB]  = 8'hff;
            end
        end
    end

    genvar i;
    generate
        for (i = 0; i < 3; i = i + 1) begin : g_flag
            always @(posedge SYS_CLK) begin
                if (RST) begin
                    // straps must float in reset so the mode can be read
                    flag_oe_q[i] <= 1'b0;
                    flag_o_q[i]  <= 1'b0;
                end else begin
                    flag_oe_q[i] <= CORE_FLAG_DIR[i];
                    flag_o_q[i]  <= CORE_FLAG_OUT[i];
                end
            end
        end
        for (i = 0; i < 4; i = i + 1) begin : g_irqf
            always @(posedge SYS_CLK) begin
                if (RST) begin
                    irq_oe_q[i] <= 1'b0;
                    irq_o_q[i]  <= 1'b0;
                end else begin
                    irq_oe_q[i] <= CORE_IRQ_FLAG_DIR[i];
                    irq_o_q[i]  <= CORE_IRQ_FLAG_OUT[i];
                end
            end
        end
    endgenerate

    always @(posedge SYS_CLK) begin
        if (RST) begin
            addr_q    <= `MMPC_RST_ADDR;
            addr_oe_q <= 14'h0000;
            dout_q    <= `MMPC_RST_DATA;
            doe_q     <= `MMPC_RST_DATA_OE;
            sel_n_q   <= `MMPC_RST_SELECTS_N;
            had_o_q   <= `MMPC_RST_HAD;
            had_oe_q  <= 16'h0000;
            ack_n_q   <= `MMPC_RST_ACK_N;
            din_q     <= `MMPC_RST_DATA;
            had_in_q  <= `MMPC_RST_HAD;
        end else begin
            addr_q    <= CORE_ADDR;
            addr_oe_q <= addr_oe_d;
            dout_q    <= dout_d;
            doe_q     <= doe_d;
            // selects run in both modes; host-mode decoding leans on them
            sel_n_q   <= CORE_SELECTS_N;
            had_o_q   <= CORE_HAD_OUT;
            had_oe_q  <= (host_q && CORE_HAD_DRIVE) ? 16'hffff : 16'h0000;
            ack_n_q   <= host_q ? CORE_HOST_ACK_N : `MMPC_RST_ACK_N;
            // lower byte is not a bus line in host mode
            din_q     <= host_q ? {data_s[23:`MMPC_UPPER_LSB], 8'h00} : data_s;
            had_in_q  <= host_q ? had_s : `MMPC_RST_HAD;
        end
    end

    // host strobes reach the core only in host mode, else held idle
    assign CORE_HOST_WR_N  = host_q ? strb_s[3] : 1'b1;
    assign CORE_HOST_RD_N  = host_q ? strb_s[2] : 1'b1;
    assign CORE_HOST_ALE   = host_q ? strb_s[1] : 1'b0;
    assign CORE_HOST_SEL_N = host_q ? strb_s[0] : 1'b1;

    assign HOST_MODE   = host_q;
    assign MODE_STRAPS = straps_q;

    assign PROG_FLAG_O      = flag_o_q;
    assign PROG_FLAG_OE     = flag_oe_q;
    assign CORE_FLAG_IN     = flag_s;

    // same pin level feeds flag reader and interrupt logic together
    assign IRQ_FLAG_O       = irq_o_q;
    assign IRQ_FLAG_OE      = irq_oe_q;
    assign CORE_IRQ_FLAG_IN = irqf_s;
    assign CORE_IRQ_REQ_N   = irqf_s;

    assign CORE_DATA_IN = din_q;
    assign EXT_ADDR_BUS = addr_q;
    assign EXT_ADDR_OE  = addr_oe_q;
    assign EXT_DATA_O   = dout_q;
    assign EXT_DATA_OE  = doe_q;

    assign COMBINED_MEM_SELECT_N = sel_n_q[3];
    assign PROGRAM_MEM_SELECT_N  = sel_n_q[2];
    assign DATA_MEM_SELECT_N     = sel_n_q[1];
    assign IO_MEM_SELECT_N       = sel_n_q[0];

    assign CORE_HAD_IN           = had_in_q;
    assign HOST_ADDR_DATA_BUS_O  = had_o_q;
    assign HOST_ADDR_DATA_BUS_OE = had_oe_q;
    assign HOST_PORT_ACK_N       = ack_n_q;

endmodule // mmpc_pin_mux

// ---- sim/mmpc_pin_mux_asserts.sv ----
/* mmpc_pin_mux_asserts.sv: port checks on the memory-mode pin mux.
   Assumes RST held 5 edges with straps stable before each release. */
`timescale 1ns/1ns
module mmpc_chk (
    // clock, reset, mode
    input wire logic        SYS_CLK, RST, HOST_MODE,
    input wire logic [2:0]  MODE_STRAPS, PROG_FLAG_I,
    // shared pins and host port
    input wire logic [3:0]  IRQ_FLAG_I, CORE_IRQ_FLAG_IN, CORE_IRQ_REQ_N,
    input wire logic        HOST_WRITE_STROBE_N, CORE_HOST_WR_N, CORE_HOST_ACK_N,
    input wire logic        HOST_PORT_ACK_N, CORE_BYTE_ACCESS,
    input wire logic [15:0] HOST_ADDR_DATA_BUS_OE,
    // external bus
    input wire logic [13:0] CORE_ADDR, EXT_ADDR_BUS, EXT_ADDR_OE,
    input wire logic [7:0]  CORE_BYTE_ADDR_HI,
    input wire logic [23:0] EXT_DATA_O, EXT_DATA_OE
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    mode_frozen_a: assert property (!$past(RST) |-> $stable(MODE_STRAPS))
        else $error("mode latch moved");
    mode_capture_a: assert property ($past(RST) |->
        MODE_STRAPS == $past(PROG_FLAG_I, 3) && HOST_MODE == MODE_STRAPS[2])
        else $error("mode not taken from straps");
    full_addr_a: assert property (!$past(RST) && !HOST_MODE |->
        EXT_ADDR_BUS == $past(CORE_ADDR) && EXT_ADDR_OE == 14'h3fff)
        else $error("full address bus wrong");
    host_addr_a: assert property (!$past(RST) && HOST_MODE |->
        EXT_ADDR_OE == 14'h0001 && EXT_ADDR_BUS[0] == $past(CORE_ADDR[0]))
        else $error("host address lsb wrong");
    byte_addr_a: assert property (!$past(RST) && !HOST_MODE && $past(CORE_BYTE_ACCESS) |->
        EXT_DATA_O[23:16] == $past(CORE_BYTE_ADDR_HI) && EXT_DATA_OE[23:16] == 8'hff)
        else $error("byte address bits wrong");
    host_data_a: assert property (HOST_MODE |-> EXT_DATA_OE[7:0] == 8'h00)
        else $error("low data byte driven");
    host_ack_a: assert property (!$past(RST) |->
        HOST_PORT_ACK_N == (!HOST_MODE || $past(CORE_HOST_ACK_N))
        && (HOST_MODE || HOST_ADDR_DATA_BUS_OE == 16'h0000))
        else $error("host port outputs wrong");
    strobe_path_a: assert property (!$past(RST) |->
        CORE_HOST_WR_N == (!HOST_MODE || $past(HOST_WRITE_STROBE_N, 2)))
        else $error("write strobe path wrong");
    irq_flag_a: assert property (!$past(RST) && !$past(RST, 2) |->
        CORE_IRQ_REQ_N == $past(IRQ_FLAG_I, 2) && CORE_IRQ_FLAG_IN == $past(IRQ_FLAG_I, 2))
        else $error("shared pin functions differ");
endmodule // mmpc_chk
bind mmpc_pin_mux mmpc_chk chk_u (.*);

// ---- sim/mmpc_far.sv ----
/* mmpc_far.sv: board around the mux: strap pulls, shared pins, io decode.
   Assumes the mux drives a pin only while its enable is high. */
`timescale 1ns/1ns
module mmpc_far (
    // strap/flag pins
    input wire logic [2:0] strap, flag_o, flag_oe,
    output logic     [2:0] flag_pin,
    // shared interrupt/flag pins
    input wire logic [3:0] irq_ext, irq_o, irq_oe,
    output logic     [3:0] irq_pin,
    // peripheral decode
    input wire logic       io_sel_n, a0,
    output logic           periph_sel
);
    // weak pull keeps strap level whenever the flag driver is off
    always_comb flag_pin = (flag_oe & flag_o) | (~flag_oe & strap);
    always_comb irq_pin = (irq_oe & irq_o) | (~irq_oe & irq_ext);
    // only a0 is left in host mode, so decode is coarse
    always_comb periph_sel = ~io_sel_n & a0;
endmodule // mmpc_far

// ---- sim/mmpc_pin_mux_tb.sv ----
/* mmpc_pin_mux_tb.sv: directed tests of the memory-mode pin mux.
   Assumes the mux and its far-side board model are compiled before. */
`timescale 1ns/1ns
module mmpc_pin_mux_tb;
    logic SYS_CLK = 0, RST = 1, HOST_MODE, CORE_DATA_DRIVE = 0, CORE_BYTE_ACCESS = 0;
    logic CORE_HAD_DRIVE = 0, CORE_HOST_ACK_N = 1, COMBINED_MEM_SELECT_N, PROGRAM_MEM_SELECT_N;
    logic DATA_MEM_SELECT_N, IO_MEM_SELECT_N, CORE_HOST_WR_N, CORE_HOST_RD_N, CORE_HOST_ALE;
    logic CORE_HOST_SEL_N, HOST_PORT_ACK_N, HOST_WRITE_STROBE_N = 1, HOST_READ_STROBE_N = 1;
    logic HOST_ADDR_LATCH = 0, HOST_PORT_SELECT_N = 1, periph_sel;
    logic [2:0] MODE_STRAPS, PROG_FLAG_I, PROG_FLAG_O, PROG_FLAG_OE, CORE_FLAG_IN, strap = 0;
    logic [2:0] CORE_FLAG_OUT = 0, CORE_FLAG_DIR = 0;
    logic [3:0] IRQ_FLAG_I, IRQ_FLAG_O, IRQ_FLAG_OE, CORE_IRQ_FLAG_IN, CORE_IRQ_REQ_N;
    logic [3:0] CORE_IRQ_FLAG_OUT = 0, CORE_IRQ_FLAG_DIR = 0, irq_ext = 4'hf, CORE_SELECTS_N = 4'hf;
    logic [7:0] CORE_BYTE_ADDR_HI = 0;
    logic [13:0] CORE_ADDR = 0, EXT_ADDR_BUS, EXT_ADDR_OE;
    logic [15:0] CORE_HAD_OUT = 0, CORE_HAD_IN, HOST_ADDR_DATA_BUS_I = 0, HOST_ADDR_DATA_BUS_O;
    logic [15:0] HOST_ADDR_DATA_BUS_OE;
    logic [23:0] CORE_DATA_OUT = 0, CORE_DATA_IN, EXT_DATA_I = 0, EXT_DATA_O, EXT_DATA_OE;
    int errors = 0, checks = 0;
    mmpc_pin_mux dut_u (.*);
    mmpc_far far_u (.strap(strap), .flag_o(PROG_FLAG_O), .flag_oe(PROG_FLAG_OE),
        .flag_pin(PROG_FLAG_I), .irq_ext(irq_ext), .irq_o(IRQ_FLAG_O), .irq_oe(IRQ_FLAG_OE),
        .irq_pin(IRQ_FLAG_I), .io_sel_n(IO_MEM_SELECT_N), .a0(EXT_ADDR_BUS[0]),
        .periph_sel(periph_sel));
    always #2 SYS_CLK = ~SYS_CLK;
    task chk(input string n, input logic [23:0] s, e);
        checks++;
        if (s !== e) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(negedge SYS_CLK);
    endtask
    task give_verdict;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // strap is moved after release to prove the latch ignores it
    task do_reset(input logic [2:0] s);
        RST = 1;
        strap = s;
        cyc(5);
        RST = 0;
        cyc(1);
        chk("mode", {MODE_STRAPS, HOST_MODE}, {s, s[2]});
        strap = ~s;
        cyc(4);
        chk("frozen", {MODE_STRAPS, HOST_MODE}, {s, s[2]});
        strap = s;
    endtask
    task t_full;
        CORE_ADDR = 14'h2a5c;
        CORE_DATA_OUT = 24'h5a3c81;
        CORE_DATA_DRIVE = 1;
        CORE_SELECTS_N = 4'h7;
        EXT_DATA_I = 24'hc3a55e;
        HOST_WRITE_STROBE_N = 0;
        cyc(1);
        chk("addr", {EXT_ADDR_OE[0], EXT_ADDR_BUS}, 15'h6a5c);
        chk("data", EXT_DATA_O, 24'h5a3c81);
        chk("dataoe_f", EXT_DATA_OE, 24'hffffff);
        chk("sel", {COMBINED_MEM_SELECT_N, PROGRAM_MEM_SELECT_N, DATA_MEM_SELECT_N,
            IO_MEM_SELECT_N}, 4'h7);
        CORE_BYTE_ACCESS = 1;
        CORE_DATA_DRIVE = 0;
        CORE_BYTE_ADDR_HI = 8'h9b;
        cyc(1);
        chk("byteoe", EXT_DATA_OE, 24'hff0000);
        chk("byteaddr", EXT_DATA_O[23:16], 8'h9b);
        cyc(1);
        chk("datain", CORE_DATA_IN, 24'hc3a55e);
        chk("hostoff", {HOST_PORT_ACK_N, CORE_HOST_WR_N, CORE_HAD_IN}, 18'h30000);
    endtask
    task t_host;
        CORE_ADDR = 14'h1555;
        CORE_DATA_DRIVE = 1;
        CORE_BYTE_ACCESS = 0;
        CORE_HAD_OUT = 16'h6c1d;
        CORE_HAD_DRIVE = 1;
        CORE_HOST_ACK_N = 0;
        CORE_SELECTS_N = 4'he;
        HOST_ADDR_DATA_BUS_I = 16'h9e27;
        HOST_READ_STROBE_N = 0;
        HOST_ADDR_LATCH = 1;
        HOST_PORT_SELECT_N = 0;
        cyc(1);
        chk("addroe", {EXT_ADDR_OE, EXT_ADDR_BUS[0]}, 15'h0003);
        chk("dataoe", EXT_DATA_OE, 24'hffff00);
        chk("hadout", {HOST_ADDR_DATA_BUS_OE[0], HOST_ADDR_DATA_BUS_O}, 17'h16c1d);
        chk("ackdec", {HOST_PORT_ACK_N, periph_sel}, 2'h1);
        cyc(1);
        chk("strobes", {CORE_HOST_WR_N, CORE_HOST_RD_N, CORE_HOST_ALE, CORE_HOST_SEL_N}, 4'h2);
        cyc(1);
        chk("hadin", CORE_HAD_IN, 16'h9e27);
        chk("datain", CORE_DATA_IN, 24'hc3a500);
    endtask
    task t_flags;
        CORE_FLAG_DIR = 3'h5;
        CORE_FLAG_OUT = 3'h3;
        CORE_IRQ_FLAG_DIR = 4'h1;
        irq_ext = 4'hb;
        cyc(3);
        chk("flags", {PROG_FLAG_OE, CORE_FLAG_IN}, 6'h29);
        chk("irqflag", {CORE_IRQ_REQ_N, CORE_IRQ_FLAG_IN}, 8'haa);
        chk("pindrv", {IRQ_FLAG_OE, IRQ_FLAG_O, PROG_FLAG_O}, 11'h083);
    endtask
    initial begin
        do_reset(3'h0);
        t_full;
        do_reset(3'h4);
        t_host;
        t_flags;
        give_verdict;
    end
    // whole run is well under 100 cycles
    initial begin
        #4000;
        errors++;
        give_verdict;
    end
endmodule // mmpc_pin_mux_tb
